// File: rtl/fault_supervisor.sv
// software fault supervisor: arm bit, 7-bit down count, halt handling
// assumes cpu strobes on mclk, option straps stable from reset onward
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - at 8 MHz, reload FFh times out in 98.304 ms, C0h in 1.536 ms
// - comes out of reset disarmed and cannot request reset until armed
// - once armed, software cannot disarm; only reset clears the arm bit
// - a write setting arm with count msb clear requests reset at once
// - hardware option keeps it permanently armed; arm bit has no function
// - wait mode changes nothing; counting and reset requests go on
// - reset-on-halt option plus armed: halt requests reset immediately
// - otherwise halt stops the countdown and blocks roll reset requests; writes still reload and can request
// - after wake by external interrupt, counting resumes after 4096 cycles
// - wake by reset leaves it in reset state, disarmed
// - control register resets to 7Fh: disarmed, count all ones
// - arm bit is set by writing one; writing zero leaves it alone
// - bits 6..0 count down; armed roll from 40h to 3Fh requests reset
// - control register sits at address 24h
// - count decrements once every 12288 cycles, 64 timeout steps
// - a reset request drives the reset line low for 500 ns
module fault_supervisor #(
	parameter int PRESCALE = sup_pkg::PRESCALE_CYCLES
) (
	input  wire logic                      mclk,
	input  wire logic                      arst_n,
	input  wire logic [sup_pkg::ADDR_W-1:0] addr,
	input  wire logic [sup_pkg::DATA_W-1:0] wdata,
	input  wire logic                      wr_en,
	input  wire logic                      rd_en,
	output logic      [sup_pkg::DATA_W-1:0] rdata,
	input  wire logic                      opt_hw_watchdog,
	input  wire logic                      opt_reset_on_halt,
	input  wire logic                      wait_mode,
	input  wire logic                      halt_exec,
	input  wire logic                      ext_wake,
	output logic                           frozen,
	output logic                           rst_req_n
);
	import sup_pkg::*;

	localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYCLES - 1);
	localparam logic [WAKE_W-1:0] WAKE_ONE  = WAKE_W'(1);

	// address decode shared by reads and writes
	function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
		return a == CTRL_ADDR;
	endfunction : is_ctrl

	// register image as software sees it
	function automatic logic [DATA_W-1:0] ctrl_word(input logic a,
	                                               input logic [CNT_W-1:0] c);
		return {a, c};
	endfunction : ctrl_word

	typedef struct packed {
		logic              arm;
		logic [CNT_W-1:0]  count;
		logic [DATA_W-1:0] rdata;
		mode_t             mode;
		logic [WAKE_W-1:0] wake_cnt;
		logic              opts_ok;
		logic              hw_opt;
		logic              halt_opt;
	} sup_t;

	sup_t st;
	sup_t next_st;

	logic tick;
	logic trig;
	logic eff_arm;
	logic wr_hit;
	logic rd_hit;
	logic dec;
	logic trig_wr;
	logic trig_dec;
	logic trig_halt;
	logic halt_go;
	logic wr_arm;

	// prescaler only runs outside halt and the wake delay
	sup_prescaler #(
		.DIV (PRESCALE)
	) u_pre (
		.mclk   (mclk),
		.arst_n (arst_n),
		.run    (st.mode == MODE_RUN),
		.tick   (tick)
	);

	// access and event decode; wait_mode deliberately plays no part
	always_comb begin
		eff_arm   = st.arm | st.hw_opt;
		wr_hit    = wr_en & is_ctrl(addr);
		rd_hit    = rd_en & is_ctrl(addr);
		dec       = tick & (st.mode == MODE_RUN);
		wr_arm    = eff_arm | wdata[ARM_POS];
		// software reset: arm with msb clear in one write
		trig_wr   = wr_hit & wr_arm & ~wdata[MSB_POS];
		// armed roll from 40h to 3Fh; a write in the same cycle wins
		trig_dec  = dec & ~wr_hit & eff_arm & (st.count == CNT_ROLL);
		trig_halt = halt_exec & st.halt_opt & eff_arm & (st.mode == MODE_RUN);
		halt_go   = halt_exec & ~trig_halt & (st.mode == MODE_RUN);
		trig      = trig_wr | trig_dec | trig_halt;
	end

	// next state
	always_comb begin
		next_st = st;
		// straps caught once, in the first cycle after reset release
		if (!st.opts_ok) begin
			next_st.opts_ok  = 1'b1;
			next_st.hw_opt   = opt_hw_watchdog;
			next_st.halt_opt = opt_reset_on_halt;
		end
		// arm bit only ever sets
		if (wr_hit && wdata[ARM_POS]) begin
			next_st.arm = 1'b1;
		end
		// reload beats decrement
		if (wr_hit) begin
			next_st.count = wdata[CNT_W-1:0];
		end else if (dec) begin
			next_st.count = st.count - CNT_STEP;
		end
		// read data stand one cycle after the strobe
		if (rd_hit) begin
			next_st.rdata = ctrl_word(eff_arm, st.count);
		end else begin
			next_st.rdata = READ_ZERO;
		end
		// halt, wake and resume
		unique case (st.mode)
			MODE_RUN: begin
				if (halt_go) begin
					next_st.mode = MODE_HALT;
				end
			end
			MODE_HALT: begin
				if (ext_wake) begin
					next_st.mode     = MODE_WAKE;
					next_st.wake_cnt = WAKE_LOAD;
				end
			end
			MODE_WAKE: begin
				if (st.wake_cnt == '0) begin
					next_st.mode = MODE_RUN;
				end else begin
					next_st.wake_cnt = st.wake_cnt - WAKE_ONE;
				end
			end
			default: begin
				next_st.mode = MODE_RUN;
			end
		endcase
	end

	// state register; any reset returns to disarmed, count 7Fh
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st.arm      <= CTRL_RESET[ARM_POS];
			st.count    <= CTRL_RESET[CNT_W-1:0];
			st.rdata    <= READ_ZERO;
			st.mode     <= MODE_RUN;
			st.wake_cnt <= '0;
			st.opts_ok  <= 1'b0;
			st.hw_opt   <= 1'b0;
			st.halt_opt <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// reset line pulse
	sup_reset_pulse #(
		.LEN (PULSE_CYCLES)
	) u_pulse (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.trig      (trig),
		.rst_req_n (rst_req_n)
	);

	assign rdata  = st.rdata;
	assign frozen = st.mode != MODE_RUN;

	// helper: cycles spent in the wake delay
	logic [WAKE_W:0] wake_len;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wake_len <= '0;
		end else if (st.mode == MODE_WAKE) begin
			wake_len <= wake_len + (WAKE_W+1)'(1);
		end else begin
			wake_len <= '0;
		end
	end

	// reference timeout steps must match the prescale period
	initial begin
		AST_STEP_TABLE: assert (STEPS_MAX == int'(RELOAD_MAX[CNT_W-1:0] - CNT_ROLL) + 1
			&& STEPS_MIN == int'(RELOAD_MIN[CNT_W-1:0] - CNT_ROLL) + 1)
			else $error("timeout table does not match step count");
	end

	sequence s_armed_roll;
		eff_arm && dec && !wr_hit && st.count == CNT_ROLL;
	endsequence

	sequence s_sw_reset;
		wr_hit && wdata[ARM_POS] && !wdata[MSB_POS];
	endsequence

	sequence s_wake_start;
		st.mode == MODE_HALT && ext_wake;
	endsequence

	AST_ARM_STICKY: assert property (
		@(posedge mclk) disable iff (!arst_n)
		st.arm |=> st.arm
	) else $error("arm bit cleared without reset");

	AST_ARM_SET: assert property (
		@(posedge mclk) disable iff (!arst_n)
		wr_hit && wdata[ARM_POS] |=> st.arm
	) else $error("arm bit not set by write");

	AST_NO_REQ_DISARMED: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!eff_arm && !(wr_hit && wdata[ARM_POS]) |-> !trig
	) else $error("reset request while disarmed");

	AST_SW_RESET: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_sw_reset |=> !rst_req_n
	) else $error("software reset not requested");

	AST_ROLL_RESET: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_armed_roll |=> !rst_req_n && st.count == CNT_ROLL - CNT_STEP
	) else $error("no reset on roll to 3Fh");

	AST_DECREMENT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		dec && !wr_hit |=> st.count == $past(st.count) - CNT_STEP
	) else $error("count did not step");

	AST_HALT_FREEZE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		st.mode != MODE_RUN && !wr_hit |=> $stable(st.count) && !trig_dec
	) else $error("count moved while frozen");

	AST_WAKE_ENTER: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_wake_start |=> st.mode == MODE_WAKE
	) else $error("wake delay not entered");

	AST_WAKE_DELAY: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$past(st.mode) == MODE_WAKE && st.mode == MODE_RUN
			|-> wake_len == (WAKE_W+1)'(WAKE_CYCLES)
	) else $error("wake delay length wrong");

	AST_HALT_RESET: assert property (
		@(posedge mclk) disable iff (!arst_n)
		trig_halt |=> !rst_req_n && st.mode == MODE_RUN
	) else $error("halt did not request reset");

	AST_HW_ARMED: assert property (
		@(posedge mclk) disable iff (!arst_n)
		rd_hit && st.hw_opt |=> rdata[ARM_POS]
	) else $error("hardware option not armed");

	AST_READBACK: assert property (
		@(posedge mclk) disable iff (!arst_n)
		rd_hit |=> rdata == ctrl_word($past(eff_arm), $past(st.count))
	) else $error("read data mismatch");

	AST_UNMAPPED: assert property (
		@(posedge mclk) disable iff (!arst_n)
		rd_en && !is_ctrl(addr) |=> rdata == READ_ZERO
	) else $error("unmapped read not zero");

	AST_HALT_ENTER: assert property (
		@(posedge mclk) disable iff (!arst_n)
		halt_go |=> st.mode == MODE_HALT && frozen
	) else $error("halt did not freeze the count");

	AST_FROZEN_NO_REQ: assert property (
		@(posedge mclk) disable iff (!arst_n)
		st.mode != MODE_RUN && !wr_hit |-> !trig
	) else $error("reset request while frozen");

	AST_WAKE_IGNORED: assert property (
		@(posedge mclk) disable iff (!arst_n)
		st.mode == MODE_RUN && ext_wake && !halt_exec |=> st.mode == MODE_RUN
	) else $error("wake outside halt changed mode");

	AST_WAIT_NO_EFFECT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		wait_mode && dec && !wr_hit |=> st.count == $past(st.count) - CNT_STEP
	) else $error("wait mode stopped the count");

	AST_RDATA_IDLE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!rd_hit |=> rdata == READ_ZERO
	) else $error("read data stood too long");
endmodule : fault_supervisor

// File: rtl/sup_pkg.sv
// constants shared by the software fault supervisor and its helpers
// assumes a single 100 MHz clock that also stands for the cpu clock
package sup_pkg;
	// register port
	localparam int             ADDR_W     = 8;
	localparam int             DATA_W     = 8;
	localparam int             CNT_W      = 7;
	localparam logic [7:0]     CTRL_ADDR  = 8'h24;
	localparam logic [7:0]     CTRL_RESET = 8'h7F;
	localparam int             ARM_POS    = 7;
	localparam int             MSB_POS    = 6;
	localparam logic [7:0]     READ_ZERO  = 8'h00;

	// count values
	localparam logic [6:0]     CNT_ROLL   = 7'h40;
	localparam logic [6:0]     CNT_STEP   = 7'h01;
	localparam logic [7:0]     RELOAD_MAX = 8'hFF;
	localparam logic [7:0]     RELOAD_MIN = 8'hC0;

	// clock and timing
	localparam int             CLK_PERIOD_NS   = 10;
	localparam int             PRESCALE_CYCLES = 12288;
	localparam int             WAKE_CYCLES     = 4096;
	localparam int             WAKE_W          = 12;
	localparam int             PULSE_NS        = 500;
	localparam int             PULSE_CYCLES    = PULSE_NS / CLK_PERIOD_NS;
	localparam int             PULSE_W         = 6;

	// reference timeouts at an 8 MHz cpu clock
	localparam int             REF_PERIOD_NS = 125;
	localparam int             TMO_MAX_NS    = 98_304_000;
	localparam int             TMO_MIN_NS    = 1_536_000;
	localparam int             STEPS_MAX     = TMO_MAX_NS / (REF_PERIOD_NS * PRESCALE_CYCLES);
	localparam int             STEPS_MIN     = TMO_MIN_NS / (REF_PERIOD_NS * PRESCALE_CYCLES);

	// run, frozen in halt, waiting out the wake delay
	typedef enum logic [1:0] {
		MODE_RUN  = 2'b00,
		MODE_HALT = 2'b01,
		MODE_WAKE = 2'b11
	} mode_t;
endpackage : sup_pkg

// File: rtl/sup_prescaler.sv
// divider that gives one enable pulse per decrement period
// assumes run is a level on mclk; the phase holds while run is low
`timescale 1ns/1ps
module sup_prescaler #(
	parameter int DIV = sup_pkg::PRESCALE_CYCLES
) (
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic run,
	output logic      tick
);
	import sup_pkg::*;

	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	localparam logic [W-1:0] ONE  = W'(1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} pre_t;

	pre_t st;
	pre_t next_st;

	// count while running, pulse once per period
	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (run) begin
			if (st.cnt == LAST) begin
				next_st.cnt  = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.cnt = st.cnt + ONE;
			end
		end
	end

	// state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule : sup_prescaler

// File: rtl/sup_reset_pulse.sv
// stretches a reset request into a fixed low pulse on the reset line
// assumes trig is a one-cycle pulse on mclk; triggers during a pulse merge
`timescale 1ns/1ps
module sup_reset_pulse #(
	parameter int LEN = sup_pkg::PULSE_CYCLES
) (
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic trig,
	output logic      rst_req_n
);
	import sup_pkg::*;

	localparam logic [PULSE_W-1:0] LOAD = PULSE_W'(LEN - 1);
	localparam logic [PULSE_W-1:0] ONE  = PULSE_W'(1);

	typedef struct packed {
		logic               req_n;
		logic [PULSE_W-1:0] left;
	} pul_t;

	pul_t st;
	pul_t next_st;

	// start on a trigger, release after LEN cycles low
	always_comb begin
		next_st = st;
		if (st.req_n) begin
			if (trig) begin
				next_st.req_n = 1'b0;
				next_st.left  = LOAD;
			end
		end else if (st.left == '0) begin
			next_st.req_n = 1'b1;
		end else begin
			next_st.left = st.left - ONE;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{req_n: 1'b1, left: '0};
		end else begin
			st <= next_st;
		end
	end

	assign rst_req_n = st.req_n;

	// helper: length of the low pulse
	logic [PULSE_W-1:0] low_len;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			low_len <= '0;
		end else if (!st.req_n) begin
			low_len <= low_len + ONE;
		end else begin
			low_len <= '0;
		end
	end

	AST_PULSE_LEN: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(st.req_n) |-> low_len == PULSE_W'(LEN)
	) else $error("reset pulse length wrong");
endmodule : sup_reset_pulse

// File: testbench/fault_supervisor_bench.sv
// bench for the software fault supervisor: reads, timeouts, halt and straps
// assumes the design files are compiled first; prescale shortened to 16
`timescale 1ns/1ps
module fault_supervisor_bench;
	import sup_pkg::*;
	localparam int PRE = 16;
	logic       mclk              = 1'b0;
	logic       arst_n            = 1'b0;
	logic [7:0] addr              = 8'h00;
	logic [7:0] wdata             = 8'h00;
	logic       wr_en             = 1'b0;
	logic       rd_en             = 1'b0;
	logic       opt_hw_watchdog   = 1'b0;
	logic       opt_reset_on_halt = 1'b0;
	logic       wait_mode         = 1'b0;
	logic       halt_exec         = 1'b0;
	logic       ext_wake          = 1'b0;
	logic [7:0] rdata;
	logic       frozen;
	logic       rst_req_n;
	int         n_errors = 0;
	int         checked  = 0;
	int         seed     = 92;
	int         m_arm; // model arm state
	int         m_cnt; // model count
	int         k;
	int         q[$];  // reload values to try
	logic [7:0] d;

	fault_supervisor #(.PRESCALE(PRE)) u_fault_supervisor (
		.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .opt_hw_watchdog(opt_hw_watchdog),
		.opt_reset_on_halt(opt_reset_on_halt), .wait_mode(wait_mode),
		.halt_exec(halt_exec), .ext_wake(ext_wake), .frozen(frozen),
		.rst_req_n(rst_req_n)
	);

	// 100 MHz clock
	always #5 mclk = ~mclk;

	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	// counts and verdict, then stop
	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	// reset held 12 cycles with the straps set beforehand
	task automatic do_reset(input logic hw, input logic roh);
		opt_hw_watchdog <= hw;
		opt_reset_on_halt <= roh;
		arst_n <= 1'b0;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		m_arm = hw;
		m_cnt = 'h7F;
		@(posedge mclk);
	endtask : do_reset

	// one-cycle write; arm only ever set by a one
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
		if (a == CTRL_ADDR) begin
			if (v[7]) m_arm = 1;
			m_cnt = v[6:0];
		end
	endtask : wr

	// one-cycle read, data looked at in the following cycle, zero checked in the cycle after
	task automatic rd_check(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		check(rdata, (a == CTRL_ADDR) ? {m_arm[0], m_cnt[6:0]} : 8'h00);
		@(posedge mclk);
		#1;
		check(rdata, 8'h00);
	endtask : rd_check

	// one-cycle pulse on halt (0) or wake (1)
	task automatic strobe(input int which);
		@(posedge mclk);
		if (which == 0) halt_exec <= 1'b1;
		else ext_wake <= 1'b1;
		@(posedge mclk);
		halt_exec <= 1'b0;
		ext_wake <= 1'b0;
	endtask : strobe

	// cycles until the reset request goes low, bounded
	task automatic time_to_req(output int t);
		t = 0;
		do begin
			@(posedge mclk);
			#1;
			t++;
		end while (rst_req_n !== 1'b0 && t < 3000);
	endtask : time_to_req

	// main sequence
	initial begin
		do_reset(1'b0, 1'b0);
		rd_check(CTRL_ADDR);
		rd_check(8'h25);
		wr(8'h25, 8'hC0);
		rd_check(CTRL_ADDR);
		$display("test reset_state done");
		// disarmed: count wraps, an msb-clear write requests nothing
		wr(CTRL_ADDR, 8'h3F);
		k = 0;
		repeat (130 * PRE) begin
			@(posedge mclk);
			#1;
			if (rst_req_n !== 1'b1) k++;
		end
		check(k, 0);
		$display("test disarmed done");
		// a wake outside halt changes nothing
		strobe(1);
		#1;
		check(frozen, 1'b0);
		// halt freezes the count; random loads read back exactly
		strobe(0);
		@(posedge mclk);
		#1;
		check(frozen, 1'b1);
		repeat (4) begin
			d = $random(seed);
			wr(CTRL_ADDR, {1'b0, d[6:0]});
			repeat (3 * PRE) @(posedge mclk);
			rd_check(CTRL_ADDR);
			check(rst_req_n, 1'b1);
		end
		strobe(1);
		#1;
		k = 0;
		while (frozen === 1'b1 && k < 5000) begin
			k++;
			@(posedge mclk);
			#1;
		end
		check(k, WAKE_CYCLES);
		$display("test halt_wake done");
		// armed timeouts: both table limits plus random reloads
		q = '{8'hFF, 8'hC0};
		repeat (3) begin
			d = $random(seed);
			q.push_back({2'b11, d[5:0]});
		end
		foreach (q[i]) begin
			do_reset(1'b0, 1'b0);
			wait_mode <= q[i][0];
			wr(CTRL_ADDR, q[i]);
			time_to_req(k);
			check(k >= (m_cnt - 'h40) * PRE + 2 && k <= (m_cnt - 'h3F) * PRE + 1, 1);
			k = 0;
			while (rst_req_n === 1'b0 && k < 200) begin
				k++;
				@(posedge mclk);
				#1;
			end
			check(k, PULSE_CYCLES);
		end
		check((q[0] - 'hBF), STEPS_MAX);
		// armed: a zero in the arm bit is ignored
		strobe(0);
		wr(CTRL_ADDR, 8'h7F);
		rd_check(CTRL_ADDR);
		do_reset(1'b0, 1'b0);
		rd_check(CTRL_ADDR);
		check(frozen, 1'b0);
		$display("test armed_timeout done");
		// deliberate reset by arming with the msb clear
		d = $random(seed);
		wr(CTRL_ADDR, {2'b10, d[5:0]});
		#1;
		check(rst_req_n, 1'b0);
		$display("test soft_reset done");
		// reset on halt strap
		do_reset(1'b0, 1'b1);
		wr(CTRL_ADDR, 8'hFF);
		strobe(0);
		#1;
		check(rst_req_n, 1'b0);
		$display("test halt_reset done");
		// hardware strap: armed from reset, times out unattended
		do_reset(1'b1, 1'b0);
		rd_check(CTRL_ADDR);
		time_to_req(k);
		check(k > 63 * PRE && k <= 64 * PRE + 4, 1);
		$display("test hw_option done");
		results();
	end

	// watchdog against a hang, well beyond the expected run
	initial begin
		#(60000 * 10);
		n_errors++;
		results();
	end
endmodule : fault_supervisor_bench
